// ### hdl/led_driver.sv
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - eight channel modulators, 8-bit duty, 97 kHz period
// - shared group modulator dims selected outputs at 190 Hz
// - blink mode: group period 24 Hz to 10.66 s, 8-bit duty
// - each output off, on, own modulator, or own plus group
// - channel brightness resets to off, linear 256 steps
// - group duty resets to full brightness
// - active-low enable pin gates every output
// - outputs update per acknowledge or at stop; reset picks stop
// - group call and three sub addresses, each software enabled
// - own 7-bit address taken from seven strap inputs
// - reset call restores every register to its power-on value
// - modulator timing derives from the block's own clock
// - serial bus works up to 1 MHz clock rate
// - glitch filter on serial clock and data before protocol logic
// - first byte after address: low five pointer, top three step
// - group call enabled at reset, sub addresses disabled
// - reset call acknowledged only with the write direction
module led_driver (
  input wire logic pclk,
  input wire logic presetn,
  input wire led_driver_pkg::apb_req_type apb_req,
  output led_driver_pkg::apb_rsp_type apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic oe_n_in,
  input wire logic [6:0] addr_strap,
  output logic [7:0] led_out,
  output logic [7:0] led_oe_n
);
  import led_driver_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  logic [9:0] meta_q;
  logic [9:0] sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 10'h380;
      sync_q <= 10'h380;
    end else begin
      meta_q <= {scl_in, sda_in, oe_n_in, addr_strap};
      sync_q <= meta_q;
    end
  end

  wire [6:0] strap_w = sync_q[6:0];
  wire oe_n_w = sync_q[7];
  logic [1:0] filt_q;

  genvar g;
  for (g = 0; g < 2; g++) begin : g_filt
    logic [2:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 3'h0;
        filt_q[g] <= 1'b1;
      end else if (sync_q[8+g] == filt_q[g]) begin
        cnt_q <= 3'h0;
      end else if (cnt_q + 3'h1 >= FILT_CYCLES) begin
        cnt_q <= 3'h0;
        filt_q[g] <= sync_q[8+g];
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  wire sda_f = filt_q[0];
  wire scl_f = filt_q[1];
  logic scl_prev_q;
  logic sda_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // edges seen at 10 MHz sampling cover a 1 MHz bus
  wire scl_rise = scl_f & ~scl_prev_q;
  wire scl_fall = ~scl_f & scl_prev_q;
  wire start_det = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  wire stop_det = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [7:0] cfg_q [NREG_RW];
  logic [7:0] live_q [NREG_RW];
  logic [7:0] led_on_q;

  function automatic logic [7:0] rst_val(input int idx);
    if (idx == int'(REG_MODE)) return MODE_RST;
    if (idx == int'(REG_GROUP_DUTY)) return DUTY_RST;
    if (idx == int'(REG_SUB1)) return SUB1_RST;
    if (idx == int'(REG_SUB2)) return SUB2_RST;
    if (idx == int'(REG_SUB3)) return SUB3_RST;
    if (idx == int'(REG_ALLCALL)) return ALLCALL_RST;
    return ZERO_RST;
  endfunction : rst_val

  function automatic logic [7:0] read_reg(input logic [4:0] idx,
                                          input logic [7:0] rw_val,
                                          input logic [6:0] strap,
                                          input logic [7:0] leds);
    if (idx < 5'(NREG_RW)) return rw_val;
    if (idx == REG_STRAP_STATUS) return {1'b0, strap};
    return leds;
  endfunction : read_reg

  mode_reg_type mode_w;
  assign mode_w = mode_reg_type'(cfg_q[REG_MODE]);
  wire blink_w = live_q[REG_MODE][1];

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  i2c_state_type st_q;
  phase_type phase_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [4:0] ptr_q;
  logic [2:0] step_q;
  logic rd_q;
  logic call_q;
  logic nack_q;
  logic sda_drive_q;

  wire [6:0] rx_addr = shift_q[7:1];
  wire rx_rw = shift_q[0];
  wire hit_own = rx_addr == strap_w;
  // extra addresses, each behind its enable bit
  wire hit_all = mode_w.all_en & (rx_addr == cfg_q[REG_ALLCALL][7:1]);
  wire hit_sub1 = mode_w.sub_en[0] & (rx_addr == cfg_q[REG_SUB1][7:1]);
  wire hit_sub2 = mode_w.sub_en[1] & (rx_addr == cfg_q[REG_SUB2][7:1]);
  wire hit_sub3 = mode_w.sub_en[2] & (rx_addr == cfg_q[REG_SUB3][7:1]);
  // reset call only with the write direction
  wire hit_call = (rx_addr == RESET_CALL_ADDR) & ~rx_rw;
  wire addr_hit = hit_own | hit_all | hit_sub1 | hit_sub2 | hit_sub3 |
                  hit_call;

  wire byte_done = scl_fall & (st_q == I2C_RX) & (bitcnt_q == 4'h8);
  wire ptr_ok = ptr_q < 5'(NREG_RW);
  wire i2c_wr = byte_done & (phase_q == PH_DATA) & ptr_ok;
  wire [4:0] ptr_inc = (ptr_q >= REG_LAST) ? 5'h00 : ptr_q + 5'h01;
  wire [4:0] ptr_adv = step_q[STEP_AUTO_BIT] ? ptr_inc : ptr_q;
  // reset call takes effect when its acknowledge ends
  wire soft_rst = scl_fall & (st_q == I2C_ACK) & call_q;
  wire [7:0] rd_cur = read_reg(ptr_q, ptr_ok ? cfg_q[ptr_q] : 8'h00,
                               strap_w, led_on_q);
  wire ptr_adv_ok = ptr_adv < 5'(NREG_RW);
  wire [7:0] rd_next = read_reg(ptr_adv, ptr_adv_ok ? cfg_q[ptr_adv] : 8'h00,
                                strap_w, led_on_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= I2C_IDLE;
      phase_q <= PH_ADDR;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 5'h00;
      step_q <= 3'h0;
      rd_q <= 1'b0;
      call_q <= 1'b0;
      nack_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end else if (stop_det) begin
      st_q <= I2C_IDLE;
      sda_drive_q <= 1'b0;
    end else if (start_det) begin
      st_q <= I2C_RX;
      phase_q <= PH_ADDR;
      bitcnt_q <= 4'h0;
      rd_q <= 1'b0;
      call_q <= 1'b0;
      sda_drive_q <= 1'b0;
    end else begin
      unique case (st_q)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (scl_rise && bitcnt_q < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_f};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_done) begin
            st_q <= I2C_ACK;
            sda_drive_q <= 1'b1;
            unique case (phase_q)
              PH_ADDR: begin
                rd_q <= rx_rw;
                call_q <= hit_call;
                if (!addr_hit) begin
                  st_q <= I2C_IDLE;
                  sda_drive_q <= 1'b0;
                end
              end
              // control byte loads pointer and step options
              PH_CTRL: begin
                ptr_q <= shift_q[4:0];
                step_q <= shift_q[7:5];
              end
              PH_DATA: ptr_q <= ptr_adv;
            endcase
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            sda_drive_q <= 1'b0;
            if (call_q) begin
              st_q <= I2C_IDLE;
              ptr_q <= 5'h00;
              step_q <= 3'h0;
            end else if (rd_q) begin
              st_q <= I2C_TX;
              shift_q <= rd_cur;
              sda_drive_q <= ~rd_cur[7];
            end else begin
              st_q <= I2C_RX;
              phase_q <= (phase_q == PH_ADDR) ? PH_CTRL : PH_DATA;
            end
          end
        end
        I2C_TX: begin
          if (scl_fall) begin
            if (bitcnt_q == 4'h7) begin
              st_q <= I2C_RACK;
              sda_drive_q <= 1'b0;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sda_drive_q <= ~shift_q[6];
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_f;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= I2C_IDLE;
            end else begin
              st_q <= I2C_TX;
              ptr_q <= ptr_adv;
              shift_q <= rd_next;
              sda_drive_q <= ~rd_next[7];
              bitcnt_q <= 4'h0;
            end
          end
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_drive_q;

  // ----------------------------------------------------------------
  // apb slave: zero wait, data and error captured in setup
  // ----------------------------------------------------------------
  wire [4:0] apb_idx = apb_req.paddr[6:2];
  wire apb_map = (apb_req.paddr[11:7] == 5'h00) &
                 (apb_req.paddr[1:0] == 2'b00) & (apb_idx <= REG_LAST);
  wire apb_rw_ok = apb_map & (apb_idx < 5'(NREG_RW));
  wire apb_setup = apb_req.psel & ~apb_req.penable;
  wire apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rw_ok;
  wire [7:0] apb_rd = read_reg(apb_idx, apb_rw_ok ? cfg_q[apb_idx] : 8'h00,
                               strap_w, led_on_q);
  logic [7:0] prdata_q;
  logic slverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 8'h00;
      slverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= (apb_map && !apb_req.pwrite) ? apb_rd : 8'h00;
      slverr_q <= apb_req.pwrite ? ~apb_rw_ok : ~apb_map;
    end
  end

  assign apb_rsp = '{prdata: {24'h000000, prdata_q}, pready: 1'b1,
                     pslverr: slverr_q};

  // staged settings: live copy follows at ack or at stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG_RW; i++) begin
        cfg_q[i] <= rst_val(i);
        live_q[i] <= rst_val(i);
      end
    end else if (soft_rst) begin
      for (int i = 0; i < NREG_RW; i++) begin
        cfg_q[i] <= rst_val(i);
        live_q[i] <= rst_val(i);
      end
    end else begin
      if (stop_det) begin
        for (int i = 0; i < NREG_RW; i++) begin
          live_q[i] <= cfg_q[i];
        end
      end
      if (i2c_wr) begin
        cfg_q[ptr_q] <= shift_q;
        if (mode_w.update_on_ack) begin
          live_q[ptr_q] <= shift_q;
        end
      end
      // bus writes from the local processor apply at once
      if (apb_wr) begin
        cfg_q[apb_idx] <= apb_req.pwdata[7:0];
        live_q[apb_idx] <= apb_req.pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // modulators
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] ch_acc_q;
  logic [ACC_W-1:0] grp_acc_q;
  logic [10:0] presc_q;
  logic [7:0] fdiv_q;
  logic [7:0] blink_ramp_q;

  // one shared accumulator per period, clock derived
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_acc_q <= '0;
      grp_acc_q <= '0;
    end else begin
      ch_acc_q <= ch_acc_q + CH_PHASE_INC;
      grp_acc_q <= grp_acc_q + GROUP_PHASE_INC;
    end
  end

  // blink period is (freq + 1) times the fastest period
  wire presc_end = presc_q == BLINK_STEP_CYCLES - 11'h001;
  wire fdiv_end = fdiv_q == live_q[REG_GROUP_FREQ];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 11'h000;
      fdiv_q <= 8'h00;
      blink_ramp_q <= 8'h00;
    end else if (presc_end) begin
      presc_q <= 11'h000;
      fdiv_q <= fdiv_end ? 8'h00 : fdiv_q + 8'h01;
      if (fdiv_end) begin
        blink_ramp_q <= blink_ramp_q + 8'h01;
      end
    end else begin
      presc_q <= presc_q + 11'h001;
    end
  end

  // linear duty: on while ramp below setting
  wire [7:0] ch_ramp = ch_acc_q[ACC_W-1 -: 8];
  // group ramp picks dim or blink timebase
  wire [7:0] grp_ramp = blink_w ? blink_ramp_q : grp_acc_q[ACC_W-1 -: 8];
  wire grp_on = grp_ramp < live_q[REG_GROUP_DUTY];
  wire [15:0] out_sel = {live_q[REG_OUT_HI], live_q[REG_OUT_LO]};
  logic [7:0] led_on_w;

  for (g = 0; g < 8; g++) begin : g_out
    wire out_mode_type om = out_mode_type'(out_sel[2*g +: 2]);
    wire ch_on = ch_ramp < live_q[int'(REG_BRIGHT0) + g];
    assign led_on_w[g] = (om == OUT_ON) | ((om == OUT_PWM) & ch_on) |
                         ((om == OUT_PWM_GROUP) & ch_on & grp_on);
  end

  // enable pin high releases every output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_on_q <= 8'h00;
    end else begin
      led_on_q <= led_on_w & {8{~oe_n_w}};
    end
  end

  assign led_out = 8'h00;
  assign led_oe_n = ~led_on_q;

endmodule : led_driver

`default_nettype wire

// ### include/led_driver_pkg.sv
`default_nettype none
package led_driver_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int OSC_HZ = 25_000_000;
  localparam int CH_PWM_HZ = 97_000;
  localparam int GROUP_DIM_HZ = 190;
  localparam int BLINK_MAX_HZ = 24;
  localparam int GLITCH_NS = 50;
  localparam int ACC_W = 24;
  localparam int RAMP_STEPS = 256;
  // phase increments: one accumulator wrap is one modulator period
  localparam logic [ACC_W-1:0] CH_PHASE_INC =
    ACC_W'((64'(CH_PWM_HZ) << ACC_W) / 64'(CLK_HZ));
  localparam logic [ACC_W-1:0] GROUP_PHASE_INC =
    ACC_W'((64'(GROUP_DIM_HZ) << ACC_W) / 64'(CLK_HZ));
  // blink ramp step at the fastest rate; slower rates repeat each step
  localparam logic [10:0] BLINK_STEP_CYCLES =
    11'(CLK_HZ / (BLINK_MAX_HZ * RAMP_STEPS));
  localparam int FILT_RAW = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FILT_CYCLES = 3'((FILT_RAW < 1) ? 1 : FILT_RAW);

  // ----------------------------------------------------------------
  // register map (index; byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_MODE = 5'h00;
  localparam logic [4:0] REG_BRIGHT0 = 5'h01;
  localparam logic [4:0] REG_GROUP_DUTY = 5'h09;
  localparam logic [4:0] REG_GROUP_FREQ = 5'h0A;
  localparam logic [4:0] REG_OUT_LO = 5'h0B;
  localparam logic [4:0] REG_OUT_HI = 5'h0C;
  localparam logic [4:0] REG_SUB1 = 5'h0D;
  localparam logic [4:0] REG_SUB2 = 5'h0E;
  localparam logic [4:0] REG_SUB3 = 5'h0F;
  localparam logic [4:0] REG_ALLCALL = 5'h10;
  localparam logic [4:0] REG_STRAP_STATUS = 5'h11;
  localparam logic [4:0] REG_LED_STATUS = 5'h12;
  localparam int NREG_RW = 17;
  localparam logic [4:0] REG_LAST = 5'h12;

  localparam logic [7:0] MODE_RST = 8'h10;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic [7:0] SUB1_RST = 8'hE2;
  localparam logic [7:0] SUB2_RST = 8'hE4;
  localparam logic [7:0] SUB3_RST = 8'hE8;
  localparam logic [7:0] ALLCALL_RST = 8'hE0;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [6:0] RESET_CALL_ADDR = 7'h03;

  localparam int STEP_AUTO_BIT = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sub_en;
    logic all_en;
    logic [1:0] unused;
    logic blink;
    logic update_on_ack;
  } mode_reg_type;

  typedef enum logic [1:0] {
    OUT_OFF, OUT_ON, OUT_PWM, OUT_PWM_GROUP
  } out_mode_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef enum {I2C_IDLE, I2C_RX, I2C_ACK, I2C_TX, I2C_RACK} i2c_state_type;
  typedef enum {PH_ADDR, PH_CTRL, PH_DATA} phase_type;

endpackage : led_driver_pkg
`default_nettype wire

// ### verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic pclk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // quarter of an 800 ns period
  task automatic qtr();
    repeat (2) @(posedge pclk);
  endtask : qtr
  // works as repeated start too
  task automatic start();
    @(posedge pclk);
    sda_drv <= 1'b1;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_drv <= 1'b0;
    qtr();
    scl <= 1'b0;
    qtr();
  endtask : start
  task automatic stop();
    sda_drv <= 1'b0;
    qtr();
    scl <= 1'b1;
    qtr();
    sda_drv <= 1'b1;
    qtr();
  endtask : stop
  // msb first, ack sampled mid high
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= (i == 0) ? 1'b1 : b[i-1];
      qtr();
      scl <= 1'b1;
      qtr();
      ack = !sda_line;
      qtr();
      scl <= 1'b0;
      qtr();
    end
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b, input logic nack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= (i == 0) ? nack : 1'b1;
      qtr();
      scl <= 1'b1;
      qtr();
      if (i > 0) b[i-1] = sda_line;
      qtr();
      scl <= 1'b0;
      qtr();
    end
  endtask : get_byte
endmodule : i2c_host_model
`default_nettype wire

// ### verif/i2c_led_pwm_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %0t: got %0h want %0h", $time, g, e); end end
module i2c_led_pwm_driver_bench;
  import led_driver_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_type req = '0;
  apb_rsp_type rsp;
  logic oe_n = 1'b1;
  logic [6:0] strap = 7'h20;
  logic scl, sda_drv, sda_oe_n, sda_out, ack, e;
  logic [7:0] led_out, led_oe_n, d;
  logic [31:0] lf = 32'h484B2D05;
  int num_errors = 0;
  int comparisons = 0;
  int lit[8];
  int rises[8];
  logic [4:0] ri[9] = '{REG_MODE, REG_BRIGHT0, REG_GROUP_DUTY, REG_GROUP_FREQ,
    REG_OUT_LO, REG_SUB1, REG_SUB2, REG_SUB3, REG_ALLCALL};
  logic [7:0] rv[9] = '{MODE_RST, ZERO_RST, DUTY_RST, ZERO_RST, ZERO_RST,
    SUB1_RST, SUB2_RST, SUB3_RST, ALLCALL_RST};
  // released sda floats high through the pull-up
  wire logic sda_line = sda_drv & (sda_oe_n | sda_out);
  always #50 pclk = ~pclk;
  led_driver DUT (.pclk, .presetn, .apb_req(req), .apb_rsp(rsp),
    .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe_n, .oe_n_in(oe_n),
    .addr_strap(strap), .led_out, .led_oe_n);
  i2c_host_model host (.pclk, .scl, .sda_drv, .sda_line);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic near(input int got, input int n, input int duty);
    return (got - n * duty / 256) <= n / 8 && (n * duty / 256 - got) <= n / 8;
  endfunction : near
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] w);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
             pwdata: {24'h0, w}};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    d = rsp.prdata[7:0];
    e = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    apb(1'b1, {5'h0, i, 2'b00}, v);
  endtask : wr
  task automatic rd(input logic [4:0] i);
    apb(1'b0, {5'h0, i, 2'b00}, 8'h00);
  endtask : rd
  task automatic measure(input int n);
    logic [7:0] p;
    // outputs are registered: let the edge after the last write land first
    @(posedge pclk);
    lit = '{default: 0};
    rises = '{default: 0};
    p = 8'hFF;
    repeat (n) begin
      @(negedge pclk);
      for (int c = 0; c < 8; c++) begin
        lit[c] += int'(led_oe_n[c] === 1'b0);
        rises[c] += int'(led_oe_n[c] === 1'b0 && p[c] === 1'b1);
      end
      p = led_oe_n;
    end
  endtask : measure
  task automatic open(input logic [7:0] ctrl);
    host.start();
    host.put_byte({strap, 1'b0}, ack);
    host.put_byte(ctrl, ack);
  endtask : open
  task automatic call(input logic [7:0] a, input logic exp);
    host.start();
    host.put_byte(a, ack);
    host.stop();
    `CHK(ack, exp)
  endtask : call
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    $display("Error %0t: watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    strap <= {2'b01, lf[4:0]};
    for (int k = 0; k < 9; k++) begin
      rd(ri[k]);
      `CHK(d, rv[k])
    end
    $display("done: reset values");
    oe_n <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      wr(REG_BRIGHT0 + 5'(k), lf[7:0]);
      rd(REG_BRIGHT0 + 5'(k));
      `CHK(d, lf[7:0])
    end
    apb(1'b0, 12'h07C, 8'h00);
    `CHK({e, d}, 9'h100)
    apb(1'b0, 12'h006, 8'h00);
    `CHK(e, 1'b1)
    wr(REG_LED_STATUS, 8'hFF);
    `CHK(e, 1'b1)
    $display("done: registers");
    for (int k = 1; k < 5; k++) wr(5'(k), 8'h80);
    wr(REG_OUT_LO, 8'hE4);
    measure(1030);
    `CHK(lit[0], 0)
    `CHK(lit[1], 1030)
    `CHK(near(lit[2], 1030, 128), 1'b1)
    `CHK(rises[2] inside {[9:11]}, 1'b1)
    `CHK(near(lit[3], 1030, 128), 1'b1)
    wr(REG_GROUP_DUTY, 8'h00);
    measure(1030);
    `CHK(lit[3], 0)
    `CHK(near(lit[2], 1030, 128), 1'b1)
    wr(REG_MODE, 8'h12);
    wr(REG_GROUP_DUTY, 8'hFF);
    measure(1030);
    `CHK(near(lit[3], 1030, 128), 1'b1)
    oe_n <= 1'b1;
    measure(20);
    `CHK(lit[1] < 5 && led_oe_n === 8'hFF, 1'b1)
    `CHK({led_out, sda_out}, 9'h000)
    oe_n <= 1'b0;
    $display("done: output modes");
    open({3'b000, REG_OUT_HI});
    `CHK(ack, 1'b1)
    host.put_byte(8'h55, ack);
    measure(20);
    `CHK(led_oe_n[7:4], 4'hF)
    host.stop();
    measure(10);
    `CHK(led_oe_n[7:4], 4'h0)
    open({3'b000, REG_OUT_HI});
    host.start();
    host.put_byte({strap, 1'b1}, ack);
    host.get_byte(d, 1'b1);
    host.stop();
    `CHK(d, 8'h55)
    open({3'b100, 5'h06});
    host.put_byte(8'h11, ack);
    host.put_byte(8'h22, ack);
    host.stop();
    rd(5'h07);
    `CHK(d, 8'h22)
    $display("done: serial write");
    call(8'hE2, 1'b0);
    call(8'hE0, 1'b1);
    call({strap ^ 7'h01, 1'b0}, 1'b0);
    wr(REG_MODE, 8'h20);
    call(8'hE2, 1'b1);
    call(8'hE0, 1'b0);
    call(8'h07, 1'b0);
    call(8'h06, 1'b1);
    measure(4);
    `CHK(led_oe_n, 8'hFF)
    rd(REG_MODE);
    `CHK(d, MODE_RST)
    rd(REG_OUT_HI);
    `CHK(d, ZERO_RST)
    $display("done: addressing");
    end_sim();
  end
endmodule : i2c_led_pwm_driver_bench
`default_nettype wire

// ### verif/led_driver_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module led_driver_asserts
  import led_driver_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire led_driver_pkg::apb_req_type apb_req,
  input wire led_driver_pkg::apb_rsp_type apb_rsp,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic oe_n_in,
  input wire logic [6:0] addr_strap,
  input wire logic [7:0] led_out,
  input wire logic [7:0] led_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic setup = apb_req.psel && !apb_req.penable;
  a_reset_leds_dark: assert property (
    $rose(presetn) |-> led_oe_n == 8'hFF && sda_oe_n)
    else $error("outputs active after reset");
  a_enable_gates_leds: assert property (
    oe_n_in [*4] |-> led_oe_n == 8'hFF)
    else $error("led lit while enable is high");
  a_sda_quiet_scl_high: assert property (
    scl_in [*6] |-> $stable(sda_oe_n))
    else $error("sda changed while scl high");
  a_sda_release_bound: assert property (
    $fell(sda_oe_n) |-> ##[1:100] sda_oe_n)
    else $error("sda held low too long");
  a_pready_high: assert property (
    apb_req.psel |-> apb_rsp.pready)
    else $error("pready low");
  a_unaligned_err: assert property (
    setup && apb_req.paddr[1:0] != 2'b00 |=> apb_rsp.pslverr)
    else $error("unaligned access not refused");
  a_ro_write_err: assert property (
    setup && apb_req.pwrite && apb_req.paddr == {5'h0, REG_LED_STATUS, 2'b00}
    |=> apb_rsp.pslverr)
    else $error("status write not refused");
  a_read_byte_wide: assert property (
    apb_req.psel && apb_req.penable |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
endmodule : led_driver_asserts
bind led_driver led_driver_asserts u_asserts (.pclk, .presetn, .apb_req,
  .apb_rsp, .scl_in, .sda_in, .sda_out, .sda_oe_n, .oe_n_in, .addr_strap,
  .led_out, .led_oe_n);
`default_nettype wire
